// ===== design/cts_defines.vh
`ifndef CTS_DEFINES_VH
`define CTS_DEFINES_VH
// ==========================================================
// register offsets
`define CTS_ADDR_TIMER_CTRL   8'h16
`define CTS_ADDR_BETA_CTRL    8'h17
`define CTS_ADDR_STATUS       8'h18
// ==========================================================
// reset values
`define CTS_RST_TIMER_CTRL    8'h95
`define CTS_RST_BETA_CTRL     8'h24
`define CTS_RST_STATUS        8'h10
`define CTS_RST_BAT_DETAIL    3'h7
// ==========================================================
// field positions, timer control
`define CTS_RES_SEL_BIT       7
`define CTS_DOUBLE_BIT        6
`define CTS_FAST_HI           5
`define CTS_FAST_LO           4
`define CTS_PREQ_HI           3
`define CTS_PREQ_LO           2
`define CTS_TOPOFF_HI         1
`define CTS_TOPOFF_LO         0
// field positions, beta control
`define CTS_BETA_HI           7
`define CTS_BETA_LO           5
`define CTS_THM_HI            2
`define CTS_THM_LO            0
// field positions, status
`define CTS_ATTACH_BIT        7
`define CTS_BATOK_BIT         6
`define CTS_VINOK_BIT         5
`define CTS_CHGOK_BIT         4
// ==========================================================
// timing and thermal threshold figures
`define CTS_FAST_BASE_HR      8'h03
`define CTS_FAST_STEP_HR      8'h02
`define CTS_PREQ_STEP_MIN     8'h0F
`define CTS_TOPOFF_STEP_DMIN  8'h40
`define CTS_THM_BASE_C        8'h50
`define CTS_THM_STEP_C        8'h05
`endif

// ===== design/cts_charger_regs.v
`timescale 1ns/100ps
// Summary of operation
// - bit 7 selects thermistor 100k or 10k
// - doubling bit doubles prequal and fast timers
// - fast timer field gives 3/5/7/9 hours
// - prequal field gives 15/30/45/60 minutes
// - topoff field gives 0/6.4/12.8/19.2 minutes
// - register 16h locked, 17h freely writable
// - beta field selects one of eight betas
// - thermal threshold 80 to 115 C, 5 C/step
// - status bit 7 shows battery attached
// - battery valid only for detail 001 to 101
// - input valid only when supply field 11
// - charger ok cleared by temp or timer fault
// - status read only, low nibble reads zero
// - detail battery state reported, 111 in reset
// - foldback flag when die above threshold
`include "cts_defines.vh"
module cts_charger_regs
#(
    parameter [6:0] SLAVE_ADDR = 7'h2A  // arbitrary bus address
)
(
    // clock and reset
    input  wire       ref_clk,
    input  wire       sys_rst,
    // i2c pins
    input  wire       sclIn,
    input  wire       sdaIn,
    output wire       sdaOut,
    output wire       sdaOe,
    // charger side status
    input  wire       chargerWriteLock,
    input  wire       batteryAttachedFlag,
    input  wire [2:0] batteryDetailIn,
    input  wire [1:0] inputSupplyState,
    input  wire [2:0] tempSenseDetailState,
    input  wire [1:0] safetyTimeoutState,
    input  wire [7:0] dieTempC,
    // control outputs
    output reg        thermistorResistanceSelect,
    output reg  [7:0] prequalTimeoutMin,
    output reg  [7:0] fastChargeTimeoutHr,
    output reg  [7:0] topoffDurationDmin,
    output reg  [2:0] thermistorBetaSelect,
    output reg  [7:0] thermalRegulationThresholdC,
    output reg        thermalFoldbackFlag,
    output reg  [2:0] batteryDetailState
);
    // ======================================================
    // state codes
    localparam [2:0] ST_IDLE  = 3'h0;  // waiting for start
    localparam [2:0] ST_ADDR  = 3'h1;  // address byte
    localparam [2:0] ST_AACK  = 3'h2;  // drive ack next fall
    localparam [2:0] ST_ACKH  = 3'h3;  // ack on the wire
    localparam [2:0] ST_RXB   = 3'h4;  // receiving a byte
    localparam [2:0] ST_TX    = 3'h5;  // sending a byte
    localparam [2:0] ST_TXEND = 3'h6;  // release before master ack
    localparam [2:0] ST_TXACK = 3'h7;  // sample master ack
    // ======================================================
    // registers
    reg  [2:0] sclSync_r;       // two sync stages plus history
    reg  [2:0] sdaSync_r;       // two sync stages plus history
    reg  [2:0] state_r;         // bus state
    reg  [2:0] bitCnt_r;        // bits in current byte
    reg  [7:0] rxShift_r;       // incoming byte
    reg  [7:0] txShift_r;       // outgoing byte
    reg  [7:0] pointer_r;       // register pointer
    reg        gotPointer_r;    // pointer byte received
    reg        readMode_r;      // direction of transfer
    reg        sdaOe_r;         // pull sda low
    reg        sdaOut_r;        // constant low drive level
    reg  [7:0] timerCtrl_r;     // register 16h
    reg  [7:0] betaCtrl_r;      // register 17h
    reg  [7:0] status_r;        // register 18h
    wire       sclRise  = sclSync_r[1] & ~sclSync_r[2];
    wire       sclFall  = ~sclSync_r[1] & sclSync_r[2];
    wire       busStart = sclSync_r[1] & sclSync_r[2] & sdaSync_r[2] & ~sdaSync_r[1];
    wire       busStop  = sclSync_r[1] & sclSync_r[2] & ~sdaSync_r[2] & sdaSync_r[1];
    wire [7:0] rxByte   = {rxShift_r[6:0], sdaSync_r[1]};
    assign sdaOut = sdaOut_r;
    assign sdaOe  = sdaOe_r;
    // ======================================================
    // read mux, unmapped addresses read zero
    function [7:0] readReg;
        input [7:0] addr;
        begin
            case (addr)
                `CTS_ADDR_TIMER_CTRL: readReg = timerCtrl_r;
                `CTS_ADDR_BETA_CTRL:  readReg = betaCtrl_r;
                `CTS_ADDR_STATUS:     readReg = status_r;
                default:              readReg = 8'h00;
            endcase
        end
    endfunction
    wire [7:0] readData = readReg(pointer_r);  // byte loaded at each read ack
    // ======================================================
    // pin synchronisers, only stage two and the history bit feed logic
    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            sclSync_r <= 3'h7;
            sdaSync_r <= 3'h7;
        end
        else
        begin
            sclSync_r <= {sclSync_r[1:0], sclIn};
            sdaSync_r <= {sdaSync_r[1:0], sdaIn};
        end
    end
    // ======================================================
    // i2c slave engine and register writes
    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_r      <= ST_IDLE;
            bitCnt_r     <= 3'h0;
            rxShift_r    <= 8'h00;
            txShift_r    <= 8'h00;
            pointer_r    <= 8'h00;
            gotPointer_r <= 1'b0;
            readMode_r   <= 1'b0;
            sdaOe_r      <= 1'b0;
            sdaOut_r     <= 1'b0;
            timerCtrl_r  <= `CTS_RST_TIMER_CTRL;
            betaCtrl_r   <= `CTS_RST_BETA_CTRL;
        end
        else if (busStop)  // stop ends everything, release the line
        begin
            state_r <= ST_IDLE;
            sdaOe_r <= 1'b0;
        end
        else if (busStart)  // repeated start keeps the pointer for reads
        begin
            state_r      <= ST_ADDR;
            bitCnt_r     <= 3'h0;
            gotPointer_r <= 1'b0;
            sdaOe_r      <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_IDLE: sdaOe_r <= 1'b0;  // line stays released until a start
                ST_ADDR:
                begin
                    if (sclRise)
                    begin
                        rxShift_r <= rxByte;
                        bitCnt_r  <= bitCnt_r + 3'h1;
                        if (bitCnt_r == 3'h7)  // foreign address: stay off the bus
                        begin
                            readMode_r <= rxByte[0];
                            state_r    <= (rxByte[7:1] == SLAVE_ADDR) ? ST_AACK : ST_IDLE;
                        end
                    end
                end
                ST_AACK:
                    if (sclFall)
                    begin
                        sdaOe_r <= 1'b1;
                        state_r <= ST_ACKH;
                    end
                ST_ACKH:
                begin
                    if (sclFall)
                    begin
                        bitCnt_r <= 3'h0;
                        if (readMode_r)  // first data bit goes out on this fall
                        begin
                            txShift_r <= readData;
                            sdaOe_r   <= ~readData[7];
                            pointer_r <= pointer_r + 8'h01;
                            state_r   <= ST_TX;
                        end
                        else
                        begin
                            sdaOe_r <= 1'b0;
                            state_r <= ST_RXB;
                        end
                    end
                end
                ST_RXB:
                begin
                    if (sclRise)
                    begin
                        rxShift_r <= rxByte;
                        bitCnt_r  <= bitCnt_r + 3'h1;
                        if (bitCnt_r == 3'h7)
                        begin
                            state_r <= ST_AACK;
                            if (!gotPointer_r)
                            begin
                                pointer_r    <= rxByte;
                                gotPointer_r <= 1'b1;
                            end
                            else
                            begin
                                pointer_r <= pointer_r + 8'h01;
                                // locked register keeps its value
                                if (pointer_r == `CTS_ADDR_TIMER_CTRL && !chargerWriteLock)
                                    timerCtrl_r <= rxByte;
                                if (pointer_r == `CTS_ADDR_BETA_CTRL)
                                    betaCtrl_r <= rxByte;
                                // status writes are acked and dropped
                            end
                        end
                    end
                end
                ST_TX:
                begin
                    if (sclFall)
                    begin
                        txShift_r <= {txShift_r[6:0], 1'b0};
                        sdaOe_r   <= ~txShift_r[6];
                    end
                    else if (sclRise)
                    begin
                        bitCnt_r <= bitCnt_r + 3'h1;
                        if (bitCnt_r == 3'h7)
                            state_r <= ST_TXEND;
                    end
                end
                ST_TXEND:
                    if (sclFall)
                    begin
                        sdaOe_r <= 1'b0;
                        state_r <= ST_TXACK;
                    end
                ST_TXACK:  // ack reloads next byte, nack ends the read
                    if (sclRise)
                        state_r <= sdaSync_r[1] ? ST_IDLE : ST_ACKH;
                default:
                begin
                    state_r <= ST_IDLE;
                    sdaOe_r <= 1'b0;
                end
            endcase
        end
    end
    // ======================================================
    // status register, rebuilt every cycle, low nibble zero
    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            status_r           <= `CTS_RST_STATUS;
            batteryDetailState <= `CTS_RST_BAT_DETAIL;
        end
        else
        begin
            status_r <= 8'h00;
            status_r[`CTS_ATTACH_BIT] <= batteryAttachedFlag;
            status_r[`CTS_BATOK_BIT]  <= (batteryDetailIn >= 3'h1) && (batteryDetailIn <= 3'h5);
            status_r[`CTS_VINOK_BIT]  <= (inputSupplyState == 2'h3);
            status_r[`CTS_CHGOK_BIT]  <= !((tempSenseDetailState == 3'h1) || (tempSenseDetailState == 3'h4)
                                         || (safetyTimeoutState != 2'h0));
            batteryDetailState <= batteryDetailIn;
        end
    end
    // ======================================================
    // decoded control outputs toward the charger core
    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            thermistorResistanceSelect  <= 1'b1;
            prequalTimeoutMin           <= 8'h00;
            fastChargeTimeoutHr         <= 8'h00;
            topoffDurationDmin          <= 8'h00;
            thermistorBetaSelect        <= 3'h1;
            thermalRegulationThresholdC <= 8'h00;
            thermalFoldbackFlag         <= 1'b0;
        end
        else
        begin
            // 1 means 10 kohm part, 0 means 100 kohm
            thermistorResistanceSelect <= timerCtrl_r[`CTS_RES_SEL_BIT];
            fastChargeTimeoutHr <= (`CTS_FAST_BASE_HR + `CTS_FAST_STEP_HR  // plain shift doubles, 18 h fits
                                   * {6'h00, timerCtrl_r[`CTS_FAST_HI:`CTS_FAST_LO]})
                                   << timerCtrl_r[`CTS_DOUBLE_BIT];
            prequalTimeoutMin   <= (`CTS_PREQ_STEP_MIN
                                   * ({6'h00, timerCtrl_r[`CTS_PREQ_HI:`CTS_PREQ_LO]} + 8'h01))
                                   << timerCtrl_r[`CTS_DOUBLE_BIT];
            topoffDurationDmin  <= `CTS_TOPOFF_STEP_DMIN  // tenths of a minute, never doubled
                                   * {6'h00, timerCtrl_r[`CTS_TOPOFF_HI:`CTS_TOPOFF_LO]};
            thermistorBetaSelect <= betaCtrl_r[`CTS_BETA_HI:`CTS_BETA_LO];
            thermalRegulationThresholdC <= `CTS_THM_BASE_C + `CTS_THM_STEP_C
                                           * {5'h00, betaCtrl_r[`CTS_THM_HI:`CTS_THM_LO]};
            // compares against the live threshold, one cycle late
            thermalFoldbackFlag <= (dieTempC > thermalRegulationThresholdC);
        end
    end
endmodule // cts_charger_regs

// ===== verification/cts_charger_regs_asserts.sv
`timescale 1ns/100ps
// ==========================================
// checker on the decoded outputs of the slice
module cts_charger_regs_asserts
(
    // clock and reset
    input wire       ref_clk,
    input wire       sys_rst,
    // watched ports
    input wire [2:0] batteryDetailIn,
    input wire [7:0] dieTempC,
    input wire       thermistorResistanceSelect,
    input wire [7:0] prequalTimeoutMin,
    input wire [7:0] fastChargeTimeoutHr,
    input wire [7:0] topoffDurationDmin,
    input wire [2:0] thermistorBetaSelect,
    input wire [7:0] thermalRegulationThresholdC,
    input wire       thermalFoldbackFlag,
    input wire [2:0] batteryDetailState
);
    // one domain; first edge after release checks only the detail reset value, other outputs still settling
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    a_reset_decode: assert property ($past(sys_rst, 2) && !$past(sys_rst) |->
        thermistorResistanceSelect && fastChargeTimeoutHr == 8'h05 && prequalTimeoutMin == 8'h1E
        && topoffDurationDmin == 8'h40 && thermistorBetaSelect == 3'h1 && thermalRegulationThresholdC == 8'h64)
        else $error("decoded outputs not at reset values");
    a_double_pair: assert property (!$past(sys_rst) |-> (fastChargeTimeoutHr[0]
        ? (fastChargeTimeoutHr <= 8'h09 && prequalTimeoutMin <= 8'h3C)
        : (fastChargeTimeoutHr >= 8'h06 && fastChargeTimeoutHr <= 8'h12 && prequalTimeoutMin % 30 == 0)))
        else $error("timers not doubled together");
    a_prequal_steps: assert property (!$past(sys_rst) |-> prequalTimeoutMin % 15 == 0
        && prequalTimeoutMin != 0 && prequalTimeoutMin <= 8'h78) else $error("prequal timeout off grid");
    a_topoff_steps: assert property (!$past(sys_rst) |-> topoffDurationDmin[5:0] == 6'h00)
        else $error("topoff duration off grid");
    a_thm_steps: assert property (!$past(sys_rst) |-> thermalRegulationThresholdC % 5 == 0
        && thermalRegulationThresholdC >= 8'h50 && thermalRegulationThresholdC <= 8'h73)
        else $error("threshold off grid");
    a_foldback_cmp: assert property (!$past(sys_rst) |-> thermalFoldbackFlag ==
        ($past(dieTempC) > $past(thermalRegulationThresholdC))) else $error("foldback flag wrong");
    a_detail_reset: assert property ($past(sys_rst) |-> batteryDetailState == 3'h7)
        else $error("detail state not 111 after reset");
    a_detail_copy: assert property (!$past(sys_rst) |-> batteryDetailState == $past(batteryDetailIn))
        else $error("detail state not following input");
endmodule // cts_charger_regs_asserts

bind cts_charger_regs cts_charger_regs_asserts i_chk (.*);

// ===== verification/cts_i2c_host.sv
`timescale 1ns/100ps
// ==========================================
// bit-banged bus host, slow so every phase spans 8 clocks
module cts_i2c_host
(
    // clock
    input  wire ref_clk,
    // bus lines
    input  wire sdaWire,        // resolved data line
    output reg  sclOut = 1'b1,  // clock line, idles high
    output reg  sdaLow = 1'b0   // high pulls data low
);
    // one phase, well above the 6 clock minimum
    task hp;
        repeat (8) @(posedge ref_clk);
    endtask
    // start, also used as repeated start from a low clock
    task start;
    begin
        sdaLow <= 1'b0;
        hp;
        sclOut <= 1'b1;
        hp;
        sdaLow <= 1'b1;
        hp;
        sclOut <= 1'b0;
        hp;
    end
    endtask
    // stop, then the bus stays idle
    task stop;
    begin
        sdaLow <= 1'b1;
        hp;
        sclOut <= 1'b1;
        hp;
        sdaLow <= 1'b0;
        hp;
    end
    endtask
    // nine bits msb first; a 1 releases the line so the slave may answer
    task xfer(input [8:0] tx, output [8:0] rx);
        integer i;
    begin
        for (i = 8; i >= 0; i = i - 1)
        begin
            sdaLow <= !tx[i];
            hp;
            sclOut <= 1'b1;
            hp;
            rx[i] = sdaWire;
            sclOut <= 1'b0;
            hp;
        end
    end
    endtask
endmodule // cts_i2c_host

// ===== verification/tb_charger_timer_thermal_status_regs.sv
`timescale 1ns/100ps
// ==========================================
// bench for the charger register slice
module tb_charger_timer_thermal_status_regs;
    localparam [6:0] DEV = 7'h2A;  // bus address given to the slice
    reg        ref_clk = 1'b0;
    reg        sys_rst = 1'b1;
    reg        lockIn  = 1'b0;
    reg        attach  = 1'b0;
    reg  [2:0] detail  = 3'h0;
    reg  [1:0] supply  = 2'h0;
    reg  [2:0] tsCode  = 3'h0;
    reg  [1:0] sftCode = 2'h0;
    reg  [7:0] dieTemp = 8'h00;
    reg  [8:0] rx;
    wire       sclLine, hostLow, sdaOe, sdaDrv, resSel, foldFlag;
    wire [7:0] preq, fast, topoff, thr;
    wire [2:0] beta, detOut;
    // open drain line with pull-up: low if the host pulls or the slave drives its level
    wire       sdaWire = !hostLow && (sdaOe ? sdaDrv : 1'b1);
    integer    num_errors = 0;
    integer    checks = 0;

    always #10 ref_clk = ~ref_clk;

    cts_charger_regs #(.SLAVE_ADDR(DEV)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .sclIn(sclLine),
        .sdaIn(sdaWire), .sdaOut(sdaDrv), .sdaOe(sdaOe), .chargerWriteLock(lockIn), .batteryAttachedFlag(attach),
        .batteryDetailIn(detail), .inputSupplyState(supply), .tempSenseDetailState(tsCode),
        .safetyTimeoutState(sftCode), .dieTempC(dieTemp), .thermistorResistanceSelect(resSel),
        .prequalTimeoutMin(preq), .fastChargeTimeoutHr(fast), .topoffDurationDmin(topoff),
        .thermistorBetaSelect(beta), .thermalRegulationThresholdC(thr), .thermalFoldbackFlag(foldFlag),
        .batteryDetailState(detOut));
    cts_i2c_host i_host (.ref_clk(ref_clk), .sdaWire(sdaWire), .sclOut(sclLine), .sdaLow(hostLow));

    // ==========================================
    // helpers
    task chk(input ok, input string msg);
    begin
        checks = checks + 1;
        if (!ok)
        begin
            num_errors = num_errors + 1;
            $display("BAD %0t %0s", $time, msg);
        end
    end
    endtask
    // address plus pointer, both must be acked
    task head(input [7:0] ptr);
    begin
        i_host.start;
        i_host.xfer({DEV, 1'b0, 1'b1}, rx);
        chk(rx[0] === 1'b0, "no ack on address");
        i_host.xfer({ptr, 1'b1}, rx);
        chk(rx[0] === 1'b0, "no ack on pointer");
    end
    endtask
    task wr(input [7:0] ptr, input [7:0] d);
    begin
        head(ptr);
        i_host.xfer({d, 1'b1}, rx);
        chk(rx[0] === 1'b0, "no ack on data");
        i_host.stop;
    end
    endtask
    // single byte read closed by a nack
    task rdchk(input [7:0] ptr, input [7:0] exp);
    begin
        head(ptr);
        i_host.start;
        i_host.xfer({DEV, 1'b1, 1'b1}, rx);
        chk(rx[0] === 1'b0, "no ack on read address");
        i_host.xfer(9'h1FF, rx);
        i_host.stop;
        chk(rx[8:1] === exp, "read value");
    end
    endtask

    // ==========================================
    // scenarios
    task t_timers;
        integer c, d;
    begin
        for (d = 0; d < 2; d = d + 1)
            for (c = 0; c < 4; c = c + 1)
            begin
                wr(8'h16, {1'b0, d[0], c[1:0], c[1:0], c[1:0]});
                chk(resSel === 1'b0 && topoff === 8'h40 * c[1:0], "select or topoff");
                chk(fast === (8'h03 + 8'h02 * c[1:0]) << d[0], "fast timeout");
                chk(preq === (8'h0F * (c[1:0] + 8'h01)) << d[0], "prequal timeout");
            end
    end
    endtask
    task t_beta;
        integer c;
    begin
        for (c = 0; c < 8; c = c + 1)
        begin
            wr(8'h17, {c[2:0], 2'b11, c[2:0]});
            chk(beta === c[2:0] && thr === 8'h50 + 8'h05 * c[2:0], "beta or threshold");
        end
        rdchk(8'h17, 8'hFF);
    end
    endtask
    // lock gates only the timer register; unmapped reads zero
    task t_lock;
    begin
        lockIn <= 1'b1;
        wr(8'h16, 8'h00);
        wr(8'h17, 8'h24);
        rdchk(8'h16, 8'h7F);
        rdchk(8'h17, 8'h24);
        lockIn <= 1'b0;
        wr(8'h16, 8'h95);
        rdchk(8'h16, 8'h95);
        rdchk(8'h20, 8'h00);
    end
    endtask
    // status summary over a sweep of detail codes; writes must not stick
    task t_status;
        integer i;
        reg [7:0] exp;
    begin
        for (i = 0; i < 8; i = i + 1)
        begin
            attach <= i[0];
            detail <= i[2:0];
            supply <= i[1:0];
            tsCode <= i[2:0];
            sftCode <= {i == 6, 1'b0};
            exp = {i[0], i >= 1 && i <= 5, i[1:0] == 2'b11, !(i == 1 || i == 4 || i == 6), 4'h0};
            wr(8'h18, 8'hFF);
            rdchk(8'h18, exp);
            chk(detOut === i[2:0], "detail state");
        end
    end
    endtask
    task t_fold;
    begin
        dieTemp <= 8'h64;
        repeat (3) @(posedge ref_clk);
        chk(foldFlag === 1'b0, "foldback at threshold");
        dieTemp <= 8'h65;
        repeat (3) @(posedge ref_clk);
        chk(foldFlag === 1'b1, "foldback above threshold");
    end
    endtask
    // one frame writes both control registers, one acked read returns both
    task t_burst;
    begin
        head(8'h16);
        i_host.xfer({8'h6A, 1'b1}, rx);
        chk(rx[0] === 1'b0, "no ack on first burst byte");
        i_host.xfer({8'h5B, 1'b1}, rx);
        chk(rx[0] === 1'b0, "no ack on second burst byte");
        i_host.stop;
        chk(resSel === 1'b0 && fast === 8'h0E && preq === 8'h5A && topoff === 8'h80, "burst timers");
        chk(beta === 3'h2 && thr === 8'h5F, "burst beta or threshold");
        head(8'h16);
        i_host.start;
        i_host.xfer({DEV, 1'b1, 1'b1}, rx);
        chk(rx[0] === 1'b0, "no ack on burst read address");
        i_host.xfer(9'h1FE, rx);
        chk(rx[8:1] === 8'h6A, "first burst read");
        i_host.xfer(9'h1FF, rx);
        i_host.stop;
        chk(rx[8:1] === 8'h5B, "second burst read");
    end
    endtask

    // ==========================================
    // verdict, the only exit
    task end_sim;
    begin
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask

    // main sequence
    initial
    begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk(resSel === 1'b1 && fast === 8'h05 && preq === 8'h1E && topoff === 8'h40, "timer reset");
        rdchk(8'h16, 8'h95);
        rdchk(8'h17, 8'h24);
        rdchk(8'h18, 8'h10);
        t_timers;
        t_beta;
        t_lock;
        t_status;
        t_fold;
        t_burst;
        end_sim;
    end
    // watchdog, about two and a half times the expected run
    initial
    begin
        repeat (90000) @(posedge ref_clk);
        num_errors = num_errors + 1;
        end_sim;
    end
endmodule // tb_charger_timer_thermal_status_regs
